// ---- src/sfh_core.sv ----
// module: set features command handler with task-file registers
`timescale 1ns/1ps

// Overview of operation
// - features code then command efh executes feature
// - unknown feature code aborts with error
// - completion status 50h/51h, only abort error
// - 01h enables 8-bit, 81h disables; off
// - nop codes succeed without changing state
// - 66h/cch control soft reset restore
// - restore resets only width, clock, current
// - clock and current share one setting
// - 97h takes clock level; default 0fh
// - clock codes 00h low to 0fh high
// - current limit quarter ma, fastest fit
// - 9ah reports min/max in cylinder regs
// - reported range is 2 and 8
// - out of range current clamps, no error
// - sector count used only for 97h/9ah
module sfh_core (
  input  wire logic              core_clk,
  input  wire logic              reset_n,
  input  wire sfh_pkg::sfh_req_t req,
  output logic [7:0]             rd_data,
  output logic                   xfer_8bit_en,
  output logic [7:0]             perf_level,
  output logic                   irq
);

  // ****************************************
  // decoding helpers
  // ****************************************
  function automatic logic fc_known(input logic [7:0] f);
    case (f)
      sfh_pkg::FC_W8_ON, sfh_pkg::FC_W8_OFF,
      sfh_pkg::FC_RST_OFF, sfh_pkg::FC_RST_ON,
      sfh_pkg::FC_CLOCK, sfh_pkg::FC_CURR,
      sfh_pkg::FC_NOP0, sfh_pkg::FC_NOP1,
      sfh_pkg::FC_NOP2, sfh_pkg::FC_NOP3,
      sfh_pkg::FC_NOP4, sfh_pkg::FC_NOP5: fc_known = 1'b1;
      default: fc_known = 1'b0;
    endcase
  endfunction : fc_known

  function automatic logic fc_nop(input logic [7:0] f);
    case (f)
      sfh_pkg::FC_NOP0, sfh_pkg::FC_NOP1,
      sfh_pkg::FC_NOP2, sfh_pkg::FC_NOP3,
      sfh_pkg::FC_NOP4, sfh_pkg::FC_NOP5: fc_nop = 1'b1;
      default: fc_nop = 1'b0;
    endcase
  endfunction : fc_nop

  // quarter-ma budget to the fastest level that fits
  function automatic logic [7:0] cur_level(input logic [7:0] c);
    if (c <= sfh_pkg::CUR_MIN) begin
      cur_level = sfh_pkg::LVL_LOW;
    end else if (c >= sfh_pkg::CUR_MAX) begin
      cur_level = sfh_pkg::LVL_HIGH;
    end else if (c < sfh_pkg::CUR_MID) begin
      cur_level = sfh_pkg::LVL_MID0;
    end else begin
      cur_level = sfh_pkg::LVL_MID1;
    end
  endfunction : cur_level

  // ****************************************
  // strobes
  // ****************************************
  sfh_pkg::sfh_state_reg_t s_q;
  sfh_pkg::sfh_state_reg_t s_d;
  logic                    cmd_wr;
  logic                    srst_wr;
  logic                    idle;

  assign idle    = (s_q.state == sfh_pkg::SFH_IDLE);
  assign cmd_wr  = req.wr && (req.addr == sfh_pkg::OFF_CMD);
  assign srst_wr = req.wr && (req.addr == sfh_pkg::OFF_DEVCTL)
                   && req.wdata[sfh_pkg::SRST_BIT];

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    s_d = s_q;
    s_d.rdata = 8'h00;
    // host-side task-file writes
    if (req.wr) begin
      case (req.addr)
        sfh_pkg::OFF_FEAT:   s_d.feat = req.wdata;
        sfh_pkg::OFF_SCNT:   s_d.scnt = req.wdata;
        sfh_pkg::OFF_IRQ_MK: s_d.irq_mk = req.wdata[1:0];
        sfh_pkg::OFF_IRQ_ST: s_d.irq_st = s_q.irq_st & ~req.wdata[1:0];
        default: ;
      endcase
    end
    // a command while busy is dropped; busy guards the snapshot
    case (s_q.state)
      sfh_pkg::SFH_IDLE: begin
        if (cmd_wr) begin
          s_d.cap_feat = s_q.feat;
          s_d.cap_cnt  = s_q.scnt;
          s_d.state    = sfh_pkg::SFH_EXEC;
          s_d.status   = sfh_pkg::ST_BUSY;
          if (req.wdata != sfh_pkg::CMD_SETF) begin
            s_d.cap_feat = 8'h00; // other commands abort here
          end
        end
      end
      sfh_pkg::SFH_EXEC: begin
        s_d.state  = sfh_pkg::SFH_IDLE;
        s_d.status = sfh_pkg::ST_READY;
        s_d.error  = sfh_pkg::ER_NONE;
        s_d.irq_st[sfh_pkg::IRQ_DONE] = 1'b1;
        // only 97h/9ah ever look at the count
        case (s_q.cap_feat)
          sfh_pkg::FC_W8_ON:   s_d.w8_en  = 1'b1;
          sfh_pkg::FC_W8_OFF:  s_d.w8_en  = 1'b0;
          sfh_pkg::FC_RST_OFF: s_d.rst_en = 1'b0;
          sfh_pkg::FC_RST_ON:  s_d.rst_en = 1'b1;
          sfh_pkg::FC_CLOCK:   s_d.perf   = s_q.cap_cnt;
          sfh_pkg::FC_CURR: begin
            s_d.perf   = cur_level(s_q.cap_cnt);
            s_d.cyl_lo = sfh_pkg::CUR_MIN;
            s_d.cyl_hi = sfh_pkg::CUR_MAX;
          end
          default: ; // nop codes leave settings alone
        endcase
        if (!fc_known(s_q.cap_feat)) begin
          s_d.status = sfh_pkg::ST_ERR;
          s_d.error  = sfh_pkg::ER_ABORT;
          s_d.irq_st[sfh_pkg::IRQ_ABRT] = 1'b1;
        end
      end
      default: s_d.state = sfh_pkg::SFH_IDLE;
    endcase
    // soft reset wins over a finishing command's settings
    if (srst_wr && s_q.rst_en) begin
      s_d.w8_en = 1'b0;
      s_d.perf  = sfh_pkg::LVL_HIGH;
    end
    // event set beats a same-cycle clear (set applied last above)
    if (req.rd) begin
      case (req.addr)
        sfh_pkg::OFF_FEAT:   s_d.rdata = s_q.feat;
        sfh_pkg::OFF_SCNT:   s_d.rdata = s_q.scnt;
        sfh_pkg::OFF_CYL_LO: s_d.rdata = s_q.cyl_lo;
        sfh_pkg::OFF_CYL_HI: s_d.rdata = s_q.cyl_hi;
        sfh_pkg::OFF_CMD:    s_d.rdata = s_q.status;
        sfh_pkg::OFF_ERR:    s_d.rdata = s_q.error;
        sfh_pkg::OFF_SETTG:  s_d.rdata = {6'h00, s_q.rst_en, s_q.w8_en};
        sfh_pkg::OFF_PERF:   s_d.rdata = s_q.perf;
        sfh_pkg::OFF_IRQ_ST: s_d.rdata = {6'h00, s_q.irq_st};
        sfh_pkg::OFF_IRQ_MK: s_d.rdata = {6'h00, s_q.irq_mk};
        default:             s_d.rdata = 8'h00;
      endcase
    end
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      s_q        <= '0;
      s_q.state  <= sfh_pkg::SFH_IDLE;
      s_q.status <= sfh_pkg::ST_READY;
      s_q.rst_en <= 1'b1;
      s_q.perf   <= sfh_pkg::LVL_HIGH;
    end else begin
      s_q <= s_d;
    end
  end

  assign rd_data      = s_q.rdata;
  assign xfer_8bit_en = s_q.w8_en;
  assign perf_level   = s_q.perf;
  assign irq          = |(s_q.irq_st & s_q.irq_mk);

  // ****************************************
  // checks
  // ****************************************
  a_cmd_busy: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    idle && cmd_wr |=> s_q.status == sfh_pkg::ST_BUSY ##1 !s_q.status[7])
    else $error("command did not run busy for one cycle");

  a_done_status: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    s_q.state == sfh_pkg::SFH_EXEC |=>
      s_q.status[7:1] == sfh_pkg::ST_READY[7:1] && (s_q.error & ~sfh_pkg::ER_ABORT) == 8'h00)
    else $error("completion status wrong");

  a_abort_code: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    s_q.state == sfh_pkg::SFH_EXEC && !fc_known(s_q.cap_feat) |=>
      s_q.status[0] && s_q.error == sfh_pkg::ER_ABORT)
    else $error("unknown feature not aborted");

  a_known_ok: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    s_q.state == sfh_pkg::SFH_EXEC && fc_known(s_q.cap_feat) |=>
      !s_q.status[0] && s_q.error == 8'h00)
    else $error("known feature flagged as error");

  a_width_on: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    s_q.state == sfh_pkg::SFH_EXEC && s_q.cap_feat == sfh_pkg::FC_W8_ON && !srst_wr
      |=> xfer_8bit_en)
    else $error("8-bit enable not taken");

  a_nop_still: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    s_q.state == sfh_pkg::SFH_EXEC && fc_nop(s_q.cap_feat) && !srst_wr |=>
      $stable(xfer_8bit_en) && $stable(perf_level) && $stable(s_q.rst_en))
    else $error("nop feature changed state");

  a_clock_set: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    s_q.state == sfh_pkg::SFH_EXEC && s_q.cap_feat == sfh_pkg::FC_CLOCK && !srst_wr
      |=> perf_level == $past(s_q.cap_cnt))
    else $error("clock level not taken from count");

  a_range_rpt: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    s_q.state == sfh_pkg::SFH_EXEC && s_q.cap_feat == sfh_pkg::FC_CURR |=>
      s_q.cyl_lo == 8'h02 && s_q.cyl_hi == 8'h08)
    else $error("current range not reported");

  a_soft_rest: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    srst_wr && s_q.rst_en |=> !xfer_8bit_en && perf_level == 8'h0f)
    else $error("soft reset did not restore defaults");

  a_soft_keep: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    srst_wr && !s_q.rst_en && idle |=> $stable(xfer_8bit_en) && $stable(perf_level))
    else $error("soft reset restored while disabled");

  a_snap_hold: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    !(idle && cmd_wr) |=> $stable(s_q.cap_feat) && $stable(s_q.cap_cnt))
    else $error("snapshot moved without a command");

  // ****************************************
  // checks: settings
  // ****************************************
  a_w8_off: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    s_q.state == sfh_pkg::SFH_EXEC && s_q.cap_feat == sfh_pkg::FC_W8_OFF
      |=> !xfer_8bit_en)
    else $error("8-bit disable not taken");

  a_rst_off: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    s_q.state == sfh_pkg::SFH_EXEC && s_q.cap_feat == sfh_pkg::FC_RST_OFF
      |=> !s_q.rst_en)
    else $error("restore disable not taken");

  a_rst_on: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    s_q.state == sfh_pkg::SFH_EXEC && s_q.cap_feat == sfh_pkg::FC_RST_ON
      |=> s_q.rst_en)
    else $error("restore enable not taken");

  // soft reset may override, so those cycles are left to a_soft_rest
  a_curr_low: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    s_q.state == sfh_pkg::SFH_EXEC && s_q.cap_feat == sfh_pkg::FC_CURR && !srst_wr
      && s_q.cap_cnt <= sfh_pkg::CUR_MIN |=> perf_level == sfh_pkg::LVL_LOW)
    else $error("low current budget not clamped");

  a_curr_mid: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    s_q.state == sfh_pkg::SFH_EXEC && s_q.cap_feat == sfh_pkg::FC_CURR && !srst_wr
      && s_q.cap_cnt > sfh_pkg::CUR_MIN && s_q.cap_cnt < sfh_pkg::CUR_MAX
      |=> perf_level == sfh_pkg::LVL_MID0 || perf_level == sfh_pkg::LVL_MID1)
    else $error("in-range current budget gave no middle level");

  a_curr_high: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    s_q.state == sfh_pkg::SFH_EXEC && s_q.cap_feat == sfh_pkg::FC_CURR && !srst_wr
      && s_q.cap_cnt >= sfh_pkg::CUR_MAX |=> perf_level == sfh_pkg::LVL_HIGH)
    else $error("high current budget not clamped");

  a_perf_hold: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    !(s_q.state == sfh_pkg::SFH_EXEC
      && (s_q.cap_feat == sfh_pkg::FC_CLOCK || s_q.cap_feat == sfh_pkg::FC_CURR))
      && !srst_wr |=> $stable(perf_level))
    else $error("power level moved without 97h or 9ah");

  a_width_hold: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    !(s_q.state == sfh_pkg::SFH_EXEC
      && (s_q.cap_feat == sfh_pkg::FC_W8_ON || s_q.cap_feat == sfh_pkg::FC_W8_OFF))
      && !srst_wr |=> $stable(xfer_8bit_en))
    else $error("8-bit setting moved without 01h or 81h");

  a_restore_hold: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    !(s_q.state == sfh_pkg::SFH_EXEC
      && (s_q.cap_feat == sfh_pkg::FC_RST_OFF || s_q.cap_feat == sfh_pkg::FC_RST_ON))
      |=> $stable(s_q.rst_en))
    else $error("restore enable moved without 66h or cch");

  a_cyl_hold: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    !(s_q.state == sfh_pkg::SFH_EXEC && s_q.cap_feat == sfh_pkg::FC_CURR)
      |=> $stable(s_q.cyl_lo) && $stable(s_q.cyl_hi))
    else $error("cylinder registers moved without 9ah");

  // ****************************************
  // checks: status and flags
  // ****************************************
  a_exec_one: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    s_q.state == sfh_pkg::SFH_EXEC |=> idle)
    else $error("command ran longer than one cycle");

  a_busy_hold: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    s_q.state == sfh_pkg::SFH_EXEC |-> s_q.status == sfh_pkg::ST_BUSY)
    else $error("busy not shown while executing");

  a_idle_final: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    idle |-> s_q.status == sfh_pkg::ST_READY || s_q.status == sfh_pkg::ST_ERR)
    else $error("idle status not a completion value");

  a_err_code: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    s_q.error == sfh_pkg::ER_NONE || s_q.error == sfh_pkg::ER_ABORT)
    else $error("error register holds more than abort");

  a_err_pair: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    idle |-> s_q.status[0] == (s_q.error == sfh_pkg::ER_ABORT))
    else $error("status error bit and abort bit disagree");

  a_done_flag: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    s_q.state == sfh_pkg::SFH_EXEC |=> s_q.irq_st[sfh_pkg::IRQ_DONE])
    else $error("done flag not raised");

  a_abort_flag: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    s_q.state == sfh_pkg::SFH_EXEC && !fc_known(s_q.cap_feat)
      |=> s_q.irq_st[sfh_pkg::IRQ_ABRT])
    else $error("abort flag not raised");

  a_ok_noabort: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    s_q.state == sfh_pkg::SFH_EXEC && fc_known(s_q.cap_feat)
      && !s_q.irq_st[sfh_pkg::IRQ_ABRT] |=> !s_q.irq_st[sfh_pkg::IRQ_ABRT])
    else $error("abort flag raised by a supported code");

  a_status_read: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    req.rd && req.addr == sfh_pkg::OFF_CMD |=> rd_data == $past(s_q.status))
    else $error("status read returned wrong value");

  a_non_setf: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    idle && cmd_wr && req.wdata != sfh_pkg::CMD_SETF
      |=> ##1 s_q.status == sfh_pkg::ST_ERR)
    else $error("foreign command not aborted");

  // ****************************************
  // checks: reset
  // ****************************************
  a_reset_vals: assert property (
    @(posedge core_clk)
    !reset_n |=> !xfer_8bit_en && perf_level == sfh_pkg::LVL_HIGH
      && s_q.rst_en && s_q.status == sfh_pkg::ST_READY)
    else $error("power-on settings wrong");

endmodule : sfh_core

// ---- include/sfh_pkg.sv ----
// package: constants and types of the set features handler
package sfh_pkg;

  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [3:0] OFF_FEAT   = 4'h0;
  localparam logic [3:0] OFF_SCNT   = 4'h1;
  localparam logic [3:0] OFF_CYL_LO = 4'h2;
  localparam logic [3:0] OFF_CYL_HI = 4'h3;
  localparam logic [3:0] OFF_CMD    = 4'h4;
  localparam logic [3:0] OFF_ERR    = 4'h5;
  localparam logic [3:0] OFF_DEVCTL = 4'h6;
  localparam logic [3:0] OFF_SETTG  = 4'h7;
  localparam logic [3:0] OFF_PERF   = 4'h8;
  localparam logic [3:0] OFF_IRQ_ST = 4'h9;
  localparam logic [3:0] OFF_IRQ_MK = 4'ha;

  // ****************************************
  // codes and field values
  // ****************************************
  localparam logic [7:0] CMD_SETF   = 8'hef;
  localparam logic [7:0] FC_W8_ON   = 8'h01;
  localparam logic [7:0] FC_W8_OFF  = 8'h81;
  localparam logic [7:0] FC_RST_OFF = 8'h66;
  localparam logic [7:0] FC_RST_ON  = 8'hcc;
  localparam logic [7:0] FC_CLOCK   = 8'h97;
  localparam logic [7:0] FC_CURR    = 8'h9a;
  localparam logic [7:0] FC_NOP0    = 8'h44;
  localparam logic [7:0] FC_NOP1    = 8'h55;
  localparam logic [7:0] FC_NOP2    = 8'h69;
  localparam logic [7:0] FC_NOP3    = 8'h96;
  localparam logic [7:0] FC_NOP4    = 8'haa;
  localparam logic [7:0] FC_NOP5    = 8'hbb;
  localparam logic [7:0] LVL_LOW    = 8'h00;
  localparam logic [7:0] LVL_MID0   = 8'h0a;
  localparam logic [7:0] LVL_MID1   = 8'h0b;
  localparam logic [7:0] LVL_HIGH   = 8'h0f;
  localparam logic [7:0] CUR_MIN    = 8'h02;
  localparam logic [7:0] CUR_MAX    = 8'h08;
  localparam logic [7:0] CUR_MID    = 8'h06;
  localparam logic [7:0] ST_READY   = 8'h50;
  localparam logic [7:0] ST_BUSY    = 8'h80;
  localparam logic [7:0] ST_ERR     = 8'h51;
  localparam logic [7:0] ER_ABORT   = 8'h04;
  localparam logic [7:0] ER_NONE    = 8'h00;
  localparam int         SRST_BIT   = 2;
  localparam int         IRQ_DONE   = 0;
  localparam int         IRQ_ABRT   = 1;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0] {
    SFH_IDLE = 2'b01,
    SFH_EXEC = 2'b10
  } sfh_state_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } sfh_req_t;

  typedef struct packed {
    sfh_state_t state;
    logic [7:0] feat;
    logic [7:0] scnt;
    logic [7:0] cap_feat;
    logic [7:0] cap_cnt;
    logic [7:0] cyl_lo;
    logic [7:0] cyl_hi;
    logic [7:0] status;
    logic [7:0] error;
    logic       w8_en;
    logic       rst_en;
    logic [7:0] perf;
    logic [1:0] irq_st;
    logic [1:0] irq_mk;
    logic [7:0] rdata;
  } sfh_state_reg_t;

endpackage : sfh_pkg

// ---- test/sfh_host.sv ----
// host model driving the task-file register port
`timescale 1ns/1ps
module sfh_host (
  input  wire logic         core_clk,
  input  wire logic [7:0]   rd_data,
  output sfh_pkg::sfh_req_t req
);
  // ********
  // bus cycles
  // ********
  initial req = '0;

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk);
    req.wr <= 1'b0;
  endtask : wr

  // data stands one cycle only, so sample mid-cycle
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge core_clk);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk);
    req.rd <= 1'b0;
    @(negedge core_clk);
    d = rd_data;
  endtask : rd

  // operands first, command code last
  task automatic cmd(input logic [7:0] c, input logic [7:0] f, input logic [7:0] s);
    wr(sfh_pkg::OFF_FEAT, f);
    wr(sfh_pkg::OFF_SCNT, s);
    wr(sfh_pkg::OFF_CMD, c);
  endtask : cmd
endmodule : sfh_host

// ---- test/tb.sv ----
// self-checking bench for the set features handler
`timescale 1ns/1ps
module tb;
  // ********
  // bench
  // ********
  logic              core_clk;
  logic              reset_n;
  sfh_pkg::sfh_req_t req;
  logic [7:0]        rd_data;
  logic [7:0]        perf_level;
  logic [7:0]        v;
  logic [7:0]        e_perf;
  logic              xfer_8bit_en;
  logic              irq;
  logic              e_w8;
  logic              e_rst;
  logic              e_mk;
  int                n_fail;
  int                compares;
  int                seed;
  logic [7:0] fc [12] = '{8'h01, 8'h81, 8'h44, 8'h55, 8'h66, 8'h69,
                          8'h96, 8'h97, 8'h9a, 8'haa, 8'hbb, 8'hcc};
  logic [7:0] cb [13] = '{8'h00, 8'h02, 8'h03, 8'h05, 8'h06, 8'h07, 8'h08,
                          8'hff, 8'h00, 8'h0a, 8'h0b, 8'h0e, 8'h0f};

  sfh_core uut (
    .core_clk    (core_clk),
    .reset_n     (reset_n),
    .req         (req),
    .rd_data     (rd_data),
    .xfer_8bit_en(xfer_8bit_en),
    .perf_level  (perf_level),
    .irq         (irq)
  );

  sfh_host host (
    .core_clk(core_clk),
    .rd_data (rd_data),
    .req     (req)
  );

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic give_verdict();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : give_verdict

  function automatic logic [7:0] cur_lvl(input logic [7:0] c);
    if (c <= 8'h02) return 8'h00;
    if (c <= 8'h05) return 8'h0a;
    if (c <= 8'h07) return 8'h0b;
    return 8'h0f;
  endfunction : cur_lvl

  function automatic logic known(input logic [7:0] f);
    foreach (fc[i]) if (fc[i] === f) return 1'b1;
    return 1'b0;
  endfunction : known

  task automatic run(input logic [7:0] c, input logic [7:0] f, input logic [7:0] s);
    logic ok;
    ok = (c === 8'hef) && known(f);
    host.cmd(c, f, s);
    host.wr(sfh_pkg::OFF_FEAT, ~f);
    repeat (2) @(posedge core_clk);
    if (ok && f == 8'h01) e_w8 = 1'b1;
    if (ok && f == 8'h81) e_w8 = 1'b0;
    if (ok && f == 8'h66) e_rst = 1'b0;
    if (ok && f == 8'hcc) e_rst = 1'b1;
    if (ok && f == 8'h97) e_perf = s;
    if (ok && f == 8'h9a) e_perf = cur_lvl(s);
    host.rd(sfh_pkg::OFF_CMD, v);
    chk(v, ok ? 8'h50 : 8'h51);
    host.rd(sfh_pkg::OFF_ERR, v);
    chk(v, ok ? 8'h00 : 8'h04);
    chk(perf_level, e_perf);
    chk({7'h0, xfer_8bit_en}, {7'h0, e_w8});
    host.rd(sfh_pkg::OFF_SETTG, v);
    chk(v, {6'h0, e_rst, e_w8});
    if (ok && f == 8'h9a) begin
      host.rd(sfh_pkg::OFF_CYL_LO, v);
      chk(v, 8'h02);
      host.rd(sfh_pkg::OFF_CYL_HI, v);
      chk(v, 8'h08);
    end
    chk({7'h0, irq}, {7'h0, e_mk});
    host.rd(sfh_pkg::OFF_IRQ_ST, v);
    chk({7'h0, v[0]}, 8'h01);
    chk({7'h0, v[1]}, {7'h0, !ok});
    host.wr(sfh_pkg::OFF_IRQ_ST, 8'h03);
    @(negedge core_clk);
    chk({7'h0, irq}, 8'h00);
  endtask : run

  // restore applies only while enabled; the enable itself survives
  task automatic srst();
    host.wr(sfh_pkg::OFF_DEVCTL, 8'h04);
    @(negedge core_clk);
    if (e_rst) begin
      e_w8 = 1'b0;
      e_perf = 8'h0f;
    end
    chk(perf_level, e_perf);
    chk({7'h0, xfer_8bit_en}, {7'h0, e_w8});
    host.rd(sfh_pkg::OFF_SETTG, v);
    chk(v, {6'h0, e_rst, e_w8});
  endtask : srst

  initial begin
    seed = 55;
    n_fail = 0;
    compares = 0;
    e_w8 = 1'b0;
    e_rst = 1'b1;
    e_perf = 8'h0f;
    e_mk = 1'b0;
    reset_n = 1'b0;
    repeat (2) @(posedge core_clk);
    reset_n <= 1'b1;
    host.rd(sfh_pkg::OFF_CMD, v);
    chk(v, 8'h50);
    chk(perf_level, 8'h0f);
    host.rd(sfh_pkg::OFF_SETTG, v);
    chk(v, 8'h02);
    host.rd(4'hf, v);
    chk(v, 8'h00);
    host.wr(sfh_pkg::OFF_PERF, 8'h00);
    @(negedge core_clk);
    chk(perf_level, 8'h0f);
    run(8'hef, 8'h9a, 8'h06);
    host.wr(sfh_pkg::OFF_IRQ_MK, 8'h03);
    e_mk = 1'b1;
    foreach (fc[i]) run(8'hef, fc[i], 8'($random(seed)));
    foreach (cb[i]) run(8'hef, i < 8 ? 8'h9a : 8'h97, cb[i]);
    run(8'h20, 8'h01, 8'h00);
    repeat (30) run(8'hef, 8'($random(seed)), 8'($random(seed)));
    run(8'hef, 8'h01, 8'h00);
    run(8'hef, 8'h97, 8'h00);
    srst();
    run(8'hef, 8'h66, 8'h00);
    run(8'hef, 8'h01, 8'h00);
    run(8'hef, 8'h9a, 8'h03);
    srst();
    run(8'hef, 8'hcc, 8'h00);
    srst();
    give_verdict();
  end

  // hang guard
  initial begin
    repeat (20000) @(posedge core_clk);
    n_fail++;
    give_verdict();
  end
endmodule : tb
